/* hdl/tmoc_pkg.sv */
// What this block does
// - Each timer has a fourth compare_value register, 16 read/write bits.
// - With clock_gate_enable set the pin trigger is the pin ANDed with gate.
// - ext_trigger_select picks peripheral clock, 1 kHz, 32 kHz or the pin.
// - Timer 2 option bits 7..4 swap channels 4..1 from port A to port B.
// - The irq enable register holds channel 4..1 enables in bits 4..1.
// - It holds trigger enable in bit 6, update in bit 0, the rest read 0.
// - Option, irq enable and fourth compare registers reset to zero.
// - The pending register uses the same bit positions as the enables.
// - An input channel's compare_value loads the count on each capture; bus writes still store.
package tmoc_pkg;

    localparam logic [31:0] ADDR_T1_PENDING = 32'h4000A800;
    localparam logic [31:0] ADDR_T2_PENDING = 32'h4000A804;
    localparam logic [31:0] ADDR_T1_IRQ_EN  = 32'h4000A840;
    localparam logic [31:0] ADDR_T2_IRQ_EN  = 32'h4000A844;
    localparam logic [31:0] ADDR_T1_CCR4    = 32'h4000E040;
    localparam logic [31:0] ADDR_T1_OPT     = 32'h4000E050;
    localparam logic [31:0] ADDR_T2_CCR4    = 32'h4000F040;
    localparam logic [31:0] ADDR_T2_OPT     = 32'h4000F050;

    localparam int TRIG_SEL_LSB  = 0;
    localparam int CLK_GATE_BIT  = 2;
    localparam int OPT_RSVD_BIT  = 3;
    localparam int SWAP_LSB      = 4;
    localparam int CHANS         = 4;
    localparam int OPT_W         = 8;

    localparam int UPDATE_BIT    = 0;
    localparam int CHAN1_BIT     = 1;
    localparam int CHAN4_BIT     = 4;
    localparam int TRIGGER_BIT   = 6;
    localparam int IRQ_W         = 7;
    localparam int CCR_W         = 16;
    localparam int TIMERS        = 2;

    localparam logic [IRQ_W-1:0] IRQ_MASK   = 7'h5F;
    localparam logic [OPT_W-1:0] OPT1_MASK  = 8'h0F;
    localparam logic [OPT_W-1:0] OPT2_MASK  = 8'hFF;
    localparam logic [OPT_W-1:0] OPT_RESET  = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET  = 7'h00;
    localparam logic [CCR_W-1:0] CCR_RESET  = 16'h0000;
    localparam logic [31:0]      RD_UNMAPPED = 32'h00000000;

    typedef enum logic [1:0] {
        TRIG_PCLK,
        TRIG_CAL_1KHZ,
        TRIG_REF_32KHZ,
        TRIG_EXT_PIN
    } tmoc_trig_t;

endpackage : tmoc_pkg

/* hdl/tmoc_timer_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module tmoc_timer_regs
    import tmoc_pkg::*;
#(
    parameter logic [OPT_W-1:0] OPT_MASK = OPT1_MASK
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             opt_wr,
    input  wire logic [OPT_W-1:0] opt_wdata,
    input  wire logic             cfg_wr,
    input  wire logic [IRQ_W-1:0] cfg_wdata,
    input  wire logic [IRQ_W-1:0] flag_clr,
    input  wire logic [IRQ_W-1:0] events,
    input  wire logic             ccr_wr,
    input  wire logic [CCR_W-1:0] ccr_wdata,
    input  wire logic             cap_evt,
    input  wire logic             cap_is_input,
    input  wire logic [CCR_W-1:0] count_value,
    output logic      [OPT_W-1:0] opt_q,
    output logic      [IRQ_W-1:0] cfg_q,
    output logic      [IRQ_W-1:0] flag_q,
    output logic      [CCR_W-1:0] ccr_q,
    output logic                  irq_req
);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            opt_q <= OPT_RESET;
        end else if (opt_wr) begin
            // Reserved bit is stored as written; keeping it zero is software's
            opt_q <= opt_wdata & OPT_MASK;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_q <= IRQ_RESET;
        end else if (cfg_wr) begin
            cfg_q <= cfg_wdata & IRQ_MASK;
        end
    end

    // Set wins over a same-cycle write-one-to-clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flag_q <= IRQ_RESET;
        end else begin
            flag_q <= ((flag_q & ~flag_clr) | events) & IRQ_MASK;
        end
    end

    // Capture wins over a bus write so no captured count is lost
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ccr_q <= CCR_RESET;
        end else if (cap_evt && cap_is_input) begin
            ccr_q <= count_value;
        end else if (ccr_wr) begin
            ccr_q <= ccr_wdata;
        end
    end

    assign irq_req = |(flag_q & cfg_q);

endmodule : tmoc_timer_regs
`default_nettype wire

/* hdl/tmoc_top.sv */
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module tmoc_top
    import tmoc_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [31:0]      avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    output logic                  irq,
    output logic                  timer1_irq_req,
    output logic                  timer2_irq_req,
    input  wire logic [IRQ_W-1:0] timer1_irq_events,
    input  wire logic [IRQ_W-1:0] timer2_irq_events,
    input  wire logic             timer1_capture4,
    input  wire logic             timer2_capture4,
    input  wire logic             timer1_chan4_is_input,
    input  wire logic             timer2_chan4_is_input,
    input  wire logic [CCR_W-1:0] timer1_count,
    input  wire logic [CCR_W-1:0] timer2_count,
    output logic      [CCR_W-1:0] timer1_compare_value,
    output logic      [CCR_W-1:0] timer2_compare_value,
    input  wire logic             cal_1khz_clock,
    input  wire logic             ref_32khz_clock,
    input  wire logic             timer1_ext_clock_pin,
    input  wire logic             timer1_gate_input,
    input  wire logic             timer2_ext_clock_pin,
    input  wire logic             timer2_gate_input,
    output logic                  timer1_trigger_tick,
    output logic                  timer2_trigger_tick,
    input  wire logic [CHANS-1:0] timer2_chan_pin_out,
    input  wire logic [CHANS-1:0] timer2_chan_pin_oe,
    output logic      [CHANS-1:0] timer2_chan_pin_in,
    input  wire logic [CHANS-1:0] port_a_chan_in,
    output logic      [CHANS-1:0] port_a_chan_out,
    output logic      [CHANS-1:0] port_a_chan_oe,
    input  wire logic [CHANS-1:0] port_b_chan_in,
    output logic      [CHANS-1:0] port_b_chan_out,
    output logic      [CHANS-1:0] port_b_chan_oe
);

    localparam int SYNC_W = 6 + 2 * CHANS;

    // Bus slave: one wait cycle, read data registered in that cycle
    logic        done_q;
    logic        req;
    logic        wr_acc;
    logic [31:0] be_mask;
    logic [31:0] rd_mux;
    logic [31:0] rd_q;

    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~done_q;
    assign wr_acc          = avs_write & done_q;
    assign avs_readdata    = rd_q;
    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= req & ~done_q;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_q <= RD_UNMAPPED;
        end else if (avs_read && !done_q) begin
            rd_q <= rd_mux;
        end
    end

    logic [TIMERS-1:0][OPT_W-1:0] opt;
    logic [TIMERS-1:0][IRQ_W-1:0] cfg;
    logic [TIMERS-1:0][IRQ_W-1:0] flag;
    logic [TIMERS-1:0][CCR_W-1:0] ccr;
    logic [TIMERS-1:0]            irq_req;

    always_comb begin
        unique case (avs_address)
            ADDR_T1_PENDING: rd_mux = {25'h0000000, flag[0]};
            ADDR_T2_PENDING: rd_mux = {25'h0000000, flag[1]};
            ADDR_T1_IRQ_EN:  rd_mux = {25'h0000000, cfg[0]};
            ADDR_T2_IRQ_EN:  rd_mux = {25'h0000000, cfg[1]};
            ADDR_T1_CCR4:    rd_mux = {16'h0000, ccr[0]};
            ADDR_T2_CCR4:    rd_mux = {16'h0000, ccr[1]};
            ADDR_T1_OPT:     rd_mux = {24'h000000, opt[0]};
            ADDR_T2_OPT:     rd_mux = {24'h000000, opt[1]};
            default:         rd_mux = RD_UNMAPPED;
        endcase
    end

    // Byte-merged write values for option, enable and compare; pending gets a byte-masked clear
    logic [TIMERS-1:0][OPT_W-1:0] opt_wdata;
    logic [TIMERS-1:0][IRQ_W-1:0] cfg_wdata;
    logic [TIMERS-1:0][IRQ_W-1:0] flag_clr;
    logic [TIMERS-1:0][CCR_W-1:0] ccr_wdata;
    logic [TIMERS-1:0]            opt_wr;
    logic [TIMERS-1:0]            cfg_wr;
    logic [TIMERS-1:0]            ccr_wr;
    logic [TIMERS-1:0]            pend_wr;
    logic [TIMERS-1:0][IRQ_W-1:0] events;
    logic [TIMERS-1:0]            cap_evt;
    logic [TIMERS-1:0]            cap_is_input;
    logic [TIMERS-1:0][CCR_W-1:0] count_value;

    assign opt_wr  = {wr_acc && avs_address == ADDR_T2_OPT,
                      wr_acc && avs_address == ADDR_T1_OPT};
    assign cfg_wr  = {wr_acc && avs_address == ADDR_T2_IRQ_EN,
                      wr_acc && avs_address == ADDR_T1_IRQ_EN};
    assign ccr_wr  = {wr_acc && avs_address == ADDR_T2_CCR4,
                      wr_acc && avs_address == ADDR_T1_CCR4};
    assign pend_wr = {wr_acc && avs_address == ADDR_T2_PENDING,
                      wr_acc && avs_address == ADDR_T1_PENDING};

    assign events       = {timer2_irq_events, timer1_irq_events};
    assign cap_evt      = {timer2_capture4, timer1_capture4};
    assign cap_is_input = {timer2_chan4_is_input, timer1_chan4_is_input};
    assign count_value  = {timer2_count, timer1_count};

    genvar t;
    generate
        for (t = 0; t < TIMERS; t++) begin : g_timer
            logic [31:0] merged_opt;
            logic [31:0] merged_cfg;
            logic [31:0] merged_ccr;
            assign merged_opt = (avs_writedata & be_mask)
                              | ({24'h000000, opt[t]} & ~be_mask);
            assign merged_cfg = (avs_writedata & be_mask)
                              | ({25'h0000000, cfg[t]} & ~be_mask);
            assign merged_ccr = (avs_writedata & be_mask)
                              | ({16'h0000, ccr[t]} & ~be_mask);
            assign opt_wdata[t] = merged_opt[OPT_W-1:0];
            assign cfg_wdata[t] = merged_cfg[IRQ_W-1:0];
            assign ccr_wdata[t] = merged_ccr[CCR_W-1:0];
            assign flag_clr[t]  = pend_wr[t]
                                ? avs_writedata[IRQ_W-1:0] & be_mask[IRQ_W-1:0]
                                : IRQ_RESET;

            tmoc_timer_regs #(
                .OPT_MASK (t == 0 ? OPT1_MASK : OPT2_MASK)
            ) u_regs (
                .clock        (clock),
                .rst          (rst),
                .opt_wr       (opt_wr[t]),
                .opt_wdata    (opt_wdata[t]),
                .cfg_wr       (cfg_wr[t]),
                .cfg_wdata    (cfg_wdata[t]),
                .flag_clr     (flag_clr[t]),
                .events       (events[t]),
                .ccr_wr       (ccr_wr[t]),
                .ccr_wdata    (ccr_wdata[t]),
                .cap_evt      (cap_evt[t]),
                .cap_is_input (cap_is_input[t]),
                .count_value  (count_value[t]),
                .opt_q        (opt[t]),
                .cfg_q        (cfg[t]),
                .flag_q       (flag[t]),
                .ccr_q        (ccr[t]),
                .irq_req      (irq_req[t])
            );
        end
    endgenerate

    assign timer1_compare_value = ccr[0];
    assign timer2_compare_value = ccr[1];
    assign timer1_irq_req       = irq_req[0];
    assign timer2_irq_req       = irq_req[1];
    assign irq                  = |irq_req;

    // Two-stage synchronisers for every pin and foreign clock
    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync_s;

    assign async_in = {port_b_chan_in, port_a_chan_in,
                       timer2_gate_input, timer2_ext_clock_pin,
                       timer1_gate_input, timer1_ext_clock_pin,
                       ref_32khz_clock, cal_1khz_clock};

    genvar s;
    generate
        for (s = 0; s < SYNC_W; s++) begin : g_sync
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    sync1_q[s] <= 1'b0;
                    sync_s[s]  <= 1'b0;
                end else begin
                    sync1_q[s] <= async_in[s];
                    sync_s[s]  <= sync1_q[s];
                end
            end
        end
    endgenerate

    // Trigger source per timer; slow clocks give one tick per rising edge
    logic [TIMERS-1:0] pin_s;
    logic [TIMERS-1:0] gate_s;
    logic [TIMERS-1:0] level;
    logic [TIMERS-1:0] level_q;
    logic [TIMERS-1:0] tick_q;
    logic [TIMERS-1:0] gate_en;
    tmoc_trig_t        trig_sel [TIMERS];

    assign pin_s  = {sync_s[4], sync_s[2]};
    assign gate_s = {sync_s[5], sync_s[3]};

    generate
        for (t = 0; t < TIMERS; t++) begin : g_trig
            assign trig_sel[t] = tmoc_trig_t'(opt[t][TRIG_SEL_LSB +: 2]);
            assign gate_en[t]  = opt[t][CLK_GATE_BIT];
            always_comb begin
                unique case (trig_sel[t])
                    TRIG_PCLK:      level[t] = 1'b1;
                    TRIG_CAL_1KHZ:  level[t] = sync_s[0];
                    TRIG_REF_32KHZ: level[t] = sync_s[1];
                    TRIG_EXT_PIN:   level[t] = pin_s[t]
                                    & (gate_s[t] | ~gate_en[t]);
                endcase
            end
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    level_q[t] <= 1'b0;
                    tick_q[t]  <= 1'b0;
                end else begin
                    level_q[t] <= level[t];
                    // Peripheral clock ticks every cycle
                    tick_q[t]  <= (trig_sel[t] == TRIG_PCLK)
                                | (level[t] & ~level_q[t]);
                end
            end
        end
    endgenerate

    assign timer1_trigger_tick = tick_q[0];
    assign timer2_trigger_tick = tick_q[1];

    // Timer 2 channel routing; the unselected pin is released
    logic [CHANS-1:0] swap;
    logic [CHANS-1:0] pa_out_q;
    logic [CHANS-1:0] pa_oe_q;
    logic [CHANS-1:0] pb_out_q;
    logic [CHANS-1:0] pb_oe_q;
    logic [CHANS-1:0] ch_in_q;

    assign swap = opt[1][SWAP_LSB +: CHANS];

    genvar c;
    generate
        for (c = 0; c < CHANS; c++) begin : g_chan
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    pa_out_q[c] <= 1'b0;
                    pa_oe_q[c]  <= 1'b0;
                    pb_out_q[c] <= 1'b0;
                    pb_oe_q[c]  <= 1'b0;
                    ch_in_q[c]  <= 1'b0;
                end else begin
                    pa_out_q[c] <= timer2_chan_pin_out[c];
                    pa_oe_q[c]  <= timer2_chan_pin_oe[c] & ~swap[c];
                    pb_out_q[c] <= timer2_chan_pin_out[c];
                    pb_oe_q[c]  <= timer2_chan_pin_oe[c] & swap[c];
                    ch_in_q[c]  <= swap[c] ? sync_s[6 + CHANS + c]
                                           : sync_s[6 + c];
                end
            end
        end
    endgenerate

    assign port_a_chan_out    = pa_out_q;
    assign port_a_chan_oe     = pa_oe_q;
    assign port_b_chan_out    = pb_out_q;
    assign port_b_chan_oe     = pb_oe_q;
    assign timer2_chan_pin_in = ch_in_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    bus_one_wait_a: assert property (
        req && !avs_waitrequest |-> $past(avs_waitrequest) && $past(req))
        else $error("bus answered without one wait cycle");

    ccr4_write_a: assert property (
        wr_acc && avs_address == ADDR_T1_CCR4 && avs_byteenable == 4'hF
        && !(timer1_capture4 && timer1_chan4_is_input)
        |=> ccr[0] == $past(avs_writedata[CCR_W-1:0]))
        else $error("compare four write not stored");

    ccr4_capture_a: assert property (
        timer2_capture4 && timer2_chan4_is_input
        |=> timer2_compare_value == $past(timer2_count))
        else $error("capture did not load count");

    pin_gated_a: assert property (
        trig_sel[0] == TRIG_EXT_PIN && gate_en[0]
        |=> level_q[0] == ($past(pin_s[0]) & $past(gate_s[0])))
        else $error("gate input not applied to pin trigger");

    pin_ungated_a: assert property (
        trig_sel[1] == TRIG_EXT_PIN && !gate_en[1]
        |=> level_q[1] == $past(pin_s[1]))
        else $error("gate input used while disabled");

    pclk_tick_a: assert property (
        trig_sel[0] == TRIG_PCLK && !rst |=> timer1_trigger_tick)
        else $error("peripheral clock trigger missing tick");

    slow_tick_a: assert property (
        trig_sel[1] == TRIG_CAL_1KHZ && $rose(sync_s[0]) && $stable(opt[1])
        |=> timer2_trigger_tick ##1 !timer2_trigger_tick)
        else $error("1 kHz edge not one tick");

    chan_route_a: assert property (
        1'b1 |=> port_b_chan_oe == $past(timer2_chan_pin_oe & swap)
                 && port_a_chan_oe == $past(timer2_chan_pin_oe & ~swap))
        else $error("channel routed to wrong port");

    cfg_read_a: assert property (
        avs_read && !avs_waitrequest && avs_address == ADDR_T1_IRQ_EN
        |-> avs_readdata[31:IRQ_W] == 25'h0000000 && !avs_readdata[5])
        else $error("unused enable bits read nonzero");

    flag_set_a: assert property (
        timer1_irq_events[TRIGGER_BIT] |=> flag[0][TRIGGER_BIT])
        else $error("trigger event lost");

    irq_req_a: assert property (
        flag[1][CHAN4_BIT] && cfg[1][CHAN4_BIT] |-> timer2_irq_req && irq)
        else $error("enabled pending bit without irq");

    irq_quiet_a: assert property (
        cfg[0] == IRQ_RESET |-> !timer1_irq_req)
        else $error("irq raised with all enables clear");

endmodule : tmoc_top
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top import tmoc_pkg::*; ;
    logic             clock, rst, avs_read, avs_write, avs_waitrequest, irq;
    logic [31:0]      avs_address, avs_writedata, avs_readdata, rv, d;
    logic [3:0]       avs_byteenable, sw;
    logic             t1_req, t2_req, t1_cap, t2_cap, t1_inp, t2_inp;
    logic [IRQ_W-1:0] t1_ev, t2_ev;
    logic [CCR_W-1:0] t1_cnt, t2_cnt, t1_cv, t2_cv;
    logic             cal_clk, ref_clk, t1_pin, t1_gate, t2_pin, t2_gate;
    logic             t1_tick, t2_tick, v;
    logic [CHANS-1:0] c_out, c_oe, c_in, pa_in, pa_out, pa_oe;
    logic [CHANS-1:0] pb_in, pb_out, pb_oe;
    logic [31:0]      cur [6];
    int               n_errors, checks, cyc, i, k, n, n2;
    localparam logic [31:0] REGS [6] = '{ADDR_T1_CCR4, ADDR_T1_OPT,
        ADDR_T2_CCR4, ADDR_T2_OPT, ADDR_T1_IRQ_EN, ADDR_T2_IRQ_EN};
    localparam int OPTS [7] = '{3, 7, 7, 1, 2, 1, 0};
    localparam int SRCS [7] = '{3, 3, 3, 1, 2, 3, 0};
    localparam int EXPN [7] = '{5, 0, 5, 5, 5, 0, 48};

    always #10 clock = ~clock;

    tmoc_top u_dut (.clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .timer1_irq_req(t1_req), .timer2_irq_req(t2_req),
        .timer1_irq_events(t1_ev), .timer2_irq_events(t2_ev),
        .timer1_capture4(t1_cap), .timer2_capture4(t2_cap),
        .timer1_chan4_is_input(t1_inp), .timer2_chan4_is_input(t2_inp),
        .timer1_count(t1_cnt), .timer2_count(t2_cnt),
        .timer1_compare_value(t1_cv), .timer2_compare_value(t2_cv),
        .cal_1khz_clock(cal_clk), .ref_32khz_clock(ref_clk),
        .timer1_ext_clock_pin(t1_pin), .timer1_gate_input(t1_gate),
        .timer2_ext_clock_pin(t2_pin), .timer2_gate_input(t2_gate),
        .timer1_trigger_tick(t1_tick), .timer2_trigger_tick(t2_tick),
        .timer2_chan_pin_out(c_out), .timer2_chan_pin_oe(c_oe),
        .timer2_chan_pin_in(c_in), .port_a_chan_in(pa_in),
        .port_a_chan_out(pa_out), .port_a_chan_oe(pa_oe),
        .port_b_chan_in(pb_in), .port_b_chan_out(pb_out),
        .port_b_chan_oe(pb_oe));

    task test_done;
        $display("Counts: checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Held until the rising edge that sees waitrequest low; data taken there
    task bus(input logic w, input logic [31:0] a, input logic [31:0] dt,
             input logic [3:0] b);
        int m;
        m = 0;
        @(posedge clock);
        avs_address    <= a;
        avs_write      <= w;
        avs_read       <= !w;
        avs_writedata  <= dt;
        avs_byteenable <= b;
        do begin
            @(posedge clock);
            m++;
        end while (avs_waitrequest !== 1'b0 && m < 50);
        if (m >= 50) chk("waitrequest", 32'h0, 32'h1);
        rv = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task pulse(input int t, input logic [IRQ_W-1:0] e);
        @(posedge clock);
        if (t == 1) t1_ev <= e;
        else t2_ev <= e;
        @(posedge clock);
        t1_ev <= '0;
        t2_ev <= '0;
        @(negedge clock);
    endtask : pulse

    // Five rising edges on the chosen source, then quiet for settling
    task trig(input int s, output int cnt, output int cnt2);
        cnt = 0;
        cnt2 = 0;
        for (int j = 0; j < 48; j++) begin
            @(posedge clock);
            v = (j < 40) && (j % 8 >= 4);
            cal_clk <= (s == 1) && v;
            ref_clk <= (s == 2) && v;
            t1_pin  <= (s == 3) && v;
            t2_pin  <= (s == 3) && v;
            @(negedge clock);
            cnt += int'(t1_tick);
            cnt2 += int'(t2_tick);
        end
    endtask : trig

    function automatic logic [31:0] msk(input int r);
        case (r)
            0, 2:    return 32'h0000FFFF;
            1:       return {24'h000000, OPT1_MASK};
            3:       return {24'h000000, OPT2_MASK};
            default: return {25'h0000000, IRQ_MASK};
        endcase
    endfunction : msk

    function automatic logic [31:0] merge(input logic [31:0] o, dt,
                                          input logic [3:0] b, input int r);
        logic [31:0] bm;
        bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        return ((o & ~bm) | (dt & bm)) & msk(r);
    endfunction : merge

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        {clock, avs_read, avs_write, t1_cap, t2_cap, t1_inp, t2_inp} = '0;
        {cal_clk, ref_clk, t1_pin, t1_gate, t2_pin, t2_gate} = '0;
        {avs_address, avs_writedata, t1_cnt, t2_cnt, t1_ev, t2_ev} = '0;
        {c_out, c_oe, pa_in, pb_in} = '0;
        avs_byteenable = 4'hF;
        rst = 1'b1;
        n_errors = 0;
        checks = 0;
        cyc = 0;
        void'($urandom(32'hC9C06084));
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 6; i++) begin
            bus(1'b0, REGS[i], 32'h0, 4'hF);
            chk("reset value", 32'h0, rv);
            cur[i] = 32'h0;
        end
        $display("test reset done");
        for (k = 0; k < 24; k++) begin
            i = $urandom_range(5);
            d = $urandom;
            if (i == 1 || i == 3) d[OPT_RSVD_BIT] = 1'b0;
            sw = (k < 8) ? 4'hF : 4'($urandom);
            bus(1'b1, REGS[i], d, sw);
            cur[i] = merge(cur[i], d, sw, i);
            bus(1'b0, REGS[i], 32'h0, 4'hF);
            chk("register", cur[i], rv);
        end
        bus(1'b1, 32'h4000E044, 32'hFFFFFFFF, 4'hF);
        bus(1'b0, 32'h4000E044, 32'h0, 4'hF);
        chk("unmapped", RD_UNMAPPED, rv);
        $display("test registers done");
        @(posedge clock);
        {t1_inp, t2_inp, t1_cap, t2_cap} <= 4'hF;
        t1_cnt <= 16'($urandom);
        t2_cnt <= 16'($urandom);
        @(posedge clock);
        {t1_cap, t2_cap} <= 2'b00;
        @(negedge clock);
        chk("capture", {t2_cnt, t1_cnt}, {t2_cv, t1_cv});
        bus(1'b0, ADDR_T1_CCR4, 32'h0, 4'hF);
        chk("capture read", {16'h0000, t1_cnt}, rv);
        $display("test capture done");
        bus(1'b1, ADDR_T1_IRQ_EN, 32'h0000005F, 4'hF);
        for (k = 0; k < IRQ_W; k++) begin
            pulse(1, IRQ_W'(1 << k));
            chk("irq", {31'h0, IRQ_MASK[k]}, {31'h0, irq});
            bus(1'b0, ADDR_T1_PENDING, 32'h0, 4'hF);
            chk("pending", IRQ_MASK[k] ? 32'h1 << k : 32'h0, rv);
            bus(1'b1, ADDR_T1_PENDING, 32'h1 << k, 4'hF);
            @(negedge clock);
            chk("irq cleared", 32'h0, {31'h0, t1_req});
        end
        bus(1'b1, ADDR_T1_IRQ_EN, 32'h0000005E, 4'hF);
        pulse(1, 7'h01);
        chk("masked", 32'h0, {31'h0, irq});
        bus(1'b1, ADDR_T2_IRQ_EN, 32'h00000040, 4'hF);
        pulse(2, 7'h40);
        chk("timer2 irq", 32'h3, {30'h0, t2_req, irq});
        bus(1'b1, ADDR_T2_IRQ_EN, 32'h00000010, 4'hF);
        @(negedge clock);
        chk("timer2 masked", 32'h0, {31'h0, t2_req});
        pulse(2, 7'h10);
        chk("timer2 chan4", 32'h3, {30'h0, t2_req, irq});
        $display("test interrupts done");
        for (k = 0; k < 7; k++) begin
            bus(1'b1, ADDR_T1_OPT, OPTS[k], 4'hF);
            bus(1'b1, ADDR_T2_OPT, OPTS[k], 4'hF);
            t1_gate <= (k == 2);
            t2_gate <= (k == 2);
            trig(SRCS[k], n, n2);
            chk("ticks", EXPN[k], n);
            chk("timer2 ticks", EXPN[k], n2);
        end
        $display("test triggers done");
        for (k = 0; k < 6; k++) begin
            sw = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($urandom);
            bus(1'b1, ADDR_T2_OPT, {24'h0, sw, 4'h0}, 4'hF);
            c_oe  <= 4'hF;
            c_out <= 4'($urandom);
            pa_in <= 4'($urandom);
            pb_in <= 4'($urandom);
            repeat (5) @(posedge clock);
            @(negedge clock);
            chk("port b oe", {28'h0, sw}, {28'h0, pb_oe});
            chk("port a oe", {28'h0, ~sw}, {28'h0, pa_oe});
            chk("port b out", {28'h0, c_out & sw},
                {28'h0, pb_out & pb_oe});
            chk("port a out", {28'h0, c_out & ~sw},
                {28'h0, pa_out & pa_oe});
            chk("chan in", {28'h0, (pb_in & sw) | (pa_in & ~sw)},
                {28'h0, c_in});
        end
        $display("test remap done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
